// ### rtl/dcoc_consts.svh
// Offsets, field positions, time limits and timing for the call conditioner
`ifndef DCOC_CONSTS_SVH
`define DCOC_CONSTS_SVH
`define DCOC_CLK_MHZ      200
`define DCOC_TICK_MS      100
`define DCOC_FPS          30
`define DCOC_TPM          (60000 / `DCOC_TICK_MS)
`define DCOC_IVL_M5       5
`define DCOC_IVL_M15      15
`define DCOC_IVL_M30      30
`define DCOC_IVL_M60      60
`define DCOC_TIME_W       8
`define DCOC_TIME_MIN     8'h01
`define DCOC_TIME_MAX     8'hFA
`define DCOC_CH_W         3
`define DCOC_CNT_W        16
`define DCOC_CFG_W        16
`define DCOC_A_CTRL       12'h000
`define DCOC_A_ZEN        12'h004
`define DCOC_A_ZBIKE      12'h008
`define DCOC_A_COMB       12'h00C
`define DCOC_A_OEN        12'h010
`define DCOC_A_STAT       12'h014
`define DCOC_A_CALL       12'h018
`define DCOC_A_SCFG       12'h01C
`define DCOC_A_ZMAP       12'h040
`define DCOC_A_CCFG       12'h100
`define DCOC_A_VCNT       12'h200
`define DCOC_A_OCC        12'h220
`define DCOC_A_BCNT       12'h240
`define DCOC_CTRL_EDIT    0
`define DCOC_CTRL_EZONE   8
`define DCOC_CTRL_SAVED   31
`define DCOC_ZM_CH        0
`define DCOC_ZM_EXT       8
`define DCOC_CC_MODE      0
`define DCOC_CC_REC       2
`define DCOC_CC_TIME      8
`endif

// ### rtl/dcoc_pkg.sv
// Types shared by the call conditioner modules
package dcoc_pkg;
   typedef enum logic [1:0] {
      DCOC_MODE_PRES  = 2'h0,
      DCOC_MODE_PULSE = 2'h1,
      DCOC_MODE_EXT   = 2'h2,
      DCOC_MODE_DLY   = 2'h3
   } dcoc_mode_e;
   typedef enum logic [1:0] {
      DCOC_REC_CONST = 2'h0,
      DCOC_REC_MIN   = 2'h1,
      DCOC_REC_FIXED = 2'h2
   } dcoc_recall_e;
   typedef enum logic [2:0] {
      DCOC_IVL_5     = 3'h0,
      DCOC_IVL_15    = 3'h1,
      DCOC_IVL_30    = 3'h2,
      DCOC_IVL_60    = 3'h3,
      DCOC_IVL_CYCLE = 3'h4
   } dcoc_ivl_e;
endpackage

// ### rtl/dcoc_chan.sv
// One call conditioner: mode timing, recall and forced call
`include "dcoc_consts.svh"
`timescale 1ns/100ps
module dcoc_chan #(
   parameter int TW = `DCOC_TIME_W
) (
   input  wire logic                   clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   tick_i,
   input  wire logic                   pres_i,
   input  wire dcoc_pkg::dcoc_mode_e   mode_i,
   input  wire logic [TW-1:0]          time_i,
   input  wire logic                   recall_i,
   input  wire dcoc_pkg::dcoc_recall_e recall_sel_i,
   input  wire logic                   const_i,
   output logic                        call_o
);
   typedef struct packed {
      logic [TW-1:0] cnt;
      logic [TW+1:0] cfg;
      logic          pres;
      logic          rec;
      logic          call;
   } dcoc_chan_s;

   dcoc_chan_s    s_r;
   dcoc_chan_s    s_nxt;
   logic [TW-1:0] tlim;
   logic [TW-1:0] dcnt;
   logic          cfg_chg;
   logic          quiet;

   always_comb begin
      tlim = time_i;
      if (time_i < TW'(`DCOC_TIME_MIN)) tlim = TW'(`DCOC_TIME_MIN);
      else if (time_i > TW'(`DCOC_TIME_MAX)) tlim = TW'(`DCOC_TIME_MAX);
      dcnt    = (tick_i && s_r.cnt != '0) ? s_r.cnt - TW'(1) : s_r.cnt;
      cfg_chg = ({mode_i, time_i} != s_r.cfg);
      quiet   = !cfg_chg && !const_i && !recall_i && !s_r.rec;
      s_nxt      = s_r;
      s_nxt.pres = pres_i;
      s_nxt.rec  = recall_i;
      s_nxt.cfg  = {mode_i, time_i};
      s_nxt.cnt  = dcnt;
      if (cfg_chg) begin
         s_nxt.cnt  = '0;
         s_nxt.call = 1'b0;
         s_nxt.rec  = 1'b0; // Recall met by a reload starts afresh
      end else if (const_i) begin
         s_nxt.cnt  = '0;
         s_nxt.call = 1'b1;
      end else if (recall_i) begin
         if (!s_r.rec) begin
            s_nxt.cnt  = tlim;
            s_nxt.call = 1'b1;
         end else begin
            case (recall_sel_i)
               dcoc_pkg::DCOC_REC_MIN: s_nxt.call = (dcnt != '0);
               dcoc_pkg::DCOC_REC_FIXED: begin
                  if (tick_i && s_r.cnt == TW'(1)) begin
                     s_nxt.cnt  = tlim;
                     s_nxt.call = !s_r.call;
                  end
               end
               default: s_nxt.call = 1'b1;
            endcase
         end
      end else if (s_r.rec) begin
         s_nxt.cnt  = '0;
         s_nxt.call = 1'b0;
      end else begin
         case (mode_i)
            dcoc_pkg::DCOC_MODE_PULSE: begin
               if (pres_i && !s_r.pres) s_nxt.cnt = tlim;
               s_nxt.call = (s_nxt.cnt != '0);
            end
            dcoc_pkg::DCOC_MODE_EXT: begin
               if (pres_i) s_nxt.cnt = tlim;
               s_nxt.call = pres_i || (dcnt != '0);
            end
            dcoc_pkg::DCOC_MODE_DLY: begin
               if (!pres_i) s_nxt.cnt = '0;
               else if (tick_i && s_r.cnt != tlim) s_nxt.cnt = s_r.cnt + TW'(1);
               else s_nxt.cnt = s_r.cnt;
               s_nxt.call = pres_i && (s_nxt.cnt == tlim);
            end
            default: begin
               s_nxt.cnt  = '0;
               s_nxt.call = pres_i;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign call_o = s_r.call;

   chk_forced_call: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      const_i && !cfg_chg |=> call_o) else $error("forced call not driven");
   chk_reload_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cfg_chg |=> !call_o && s_r.cnt == '0) else $error("setting change did not reload");
   chk_presence_mode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      quiet && mode_i == dcoc_pkg::DCOC_MODE_PRES |=> call_o == $past(pres_i))
      else $error("presence call does not follow detection");
   chk_pulse_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      quiet && mode_i == dcoc_pkg::DCOC_MODE_PULSE && pres_i && !s_r.pres |=> call_o)
      else $error("pulse not started at onset");
   chk_delay_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      quiet && mode_i == dcoc_pkg::DCOC_MODE_DLY && !pres_i |=> !call_o)
      else $error("delay call without presence");
   chk_extend_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (quiet && mode_i == dcoc_pkg::DCOC_MODE_EXT && pres_i) ##1
      (quiet && mode_i == dcoc_pkg::DCOC_MODE_EXT && !pres_i && !tick_i) |=> call_o)
      else $error("extension dropped early");
   chk_recall_const: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      recall_i && s_r.rec && !const_i && !cfg_chg &&
      recall_sel_i == dcoc_pkg::DCOC_REC_CONST |=> call_o)
      else $error("constant recall not held");
endmodule // dcoc_chan

// ### rtl/dcoc_top.sv
// Detector call output conditioner with APB register access
//
// Notes on behaviour
// - Interference, poor visibility, power loss: safe call
// - Low visibility: defined zones constant call, auto-resume
// - Separate-processor build: at least 24 zones
// - Integrated build: at least 8 zones
// - Zones per output OR by default, AND selectable
// - Bicycle zones call only for bicycles, own channel
// - Each bicycle zone has its own extension
// - Six bicycle count zones binned per interval
// - Detecting zone raises overlay indication
// - Other zones keep working during zone edit
// - Outputs of edited zone hold constant call
// - Zones detect only configured travel direction
// - Video processed at 30 frames per second
// - Video loss: per-output selected recall behaviour
// - Background learning: every enabled output constant call
// - Output mode presence, pulse, extend or delay
// - Times 0.1 to 25.0 s, 0.1 s steps
// - Six statistics zones counted and stored
// - Interval 5, 15, 30, 60 min or cycle
// - Configuration changes raise a save request for non-volatile storage
`include "dcoc_consts.svh"
`timescale 1ns/100ps
module dcoc_top #(
   parameter int NZONE     = 24,
   parameter int NOUT      = 8,
   parameter int NSTAT     = 6,
   parameter int TICK_CYC  = `DCOC_TICK_MS * 1000 * `DCOC_CLK_MHZ,
   parameter int FRAME_CYC = `DCOC_CLK_MHZ * 1000000 / `DCOC_FPS
) (
   input  wire logic             CLK_SYS_I,
   input  wire logic             ARST_N_I,
   input  wire logic             PSEL_I,
   input  wire logic             PENABLE_I,
   input  wire logic             PWRITE_I,
   input  wire logic [11:0]      PADDR_I,
   input  wire logic [31:0]      PWDATA_I,
   output logic      [31:0]      PRDATA_O,
   output logic                  PREADY_O,
   output logic                  PSLVERR_O,
   input  wire logic [NZONE-1:0] ZONE_DET_I,
   input  wire logic [NZONE-1:0] ZONE_DIR_OK_I,
   input  wire logic [NZONE-1:0] ZONE_BIKE_CLS_I,
   input  wire logic [NSTAT-1:0] BIKE_CNT_DET_I,
   input  wire logic             VIDEO_OK_I,
   input  wire logic             VIDEO_INTERF_I,
   input  wire logic             POWER_FAIL_I,
   input  wire logic             LOW_VIS_I,
   input  wire logic             LEARN_I,
   input  wire logic             CYCLE_END_I,
   output logic      [NOUT-1:0]  CALL_O,
   output logic      [NZONE-1:0] ZONE_IND_O,
   output logic                  CFG_SAVE_REQ_O
);
   localparam int ZW  = $clog2(NZONE);
   localparam int TCW = $clog2(TICK_CYC + 1);
   localparam int FCW = $clog2(FRAME_CYC + 1);
   localparam int CW  = `DCOC_CNT_W;
   localparam int GW  = `DCOC_CFG_W;
   localparam int TW  = `DCOC_TIME_W;

   typedef struct packed {
      logic                      edit;
      logic [ZW-1:0]             ezone;
      logic [NZONE-1:0]          zen;
      logic [NZONE-1:0]          zbike;
      logic [NZONE-1:0]          det;
      logic [NOUT-1:0]           comb_and;
      logic [NOUT-1:0]           oen;
      dcoc_pkg::dcoc_ivl_e       ssel;
      logic [NZONE-1:0][GW-1:0]  zmap;
      logic [NOUT-1:0][GW-1:0]   ccfg;
      logic [TCW-1:0]            tick_cnt;
      logic                      tick;
      logic [FCW-1:0]            fr_cnt;
      logic [CW-1:0]             ival;
      logic [NSTAT-1:0][CW-1:0]  vcnt;
      logic [NSTAT-1:0][CW-1:0]  occ;
      logic [NSTAT-1:0][CW-1:0]  bcnt;
      logic [NSTAT-1:0][CW-1:0]  vsav;
      logic [NSTAT-1:0][CW-1:0]  osav;
      logic [NSTAT-1:0][CW-1:0]  bsav;
      logic [NSTAT-1:0]          bdet;
      logic                      dirty;
      logic                      ready;
      logic                      err;
      logic [31:0]               rdata;
   } dcoc_top_s;

   dcoc_top_s                s_r;
   dcoc_top_s                s_nxt;
   logic                     access;
   logic                     hit;
   logic [31:0]              rd;
   logic [NZONE-1:0]         hit_now;
   logic [NZONE-1:0]         zone_call;
   logic [NZONE-1:0]         zone_ext;
   logic [NZONE-1:0][TW-1:0] zone_time;
   logic [NOUT-1:0]          ch_pres;
   logic [NOUT-1:0]          ch_const;
   logic [NOUT-1:0]          ch_rec;
   logic [NOUT-1:0]          ch_def;
   logic [NOUT-1:0]          ch_edit;
   logic [NOUT-1:0]          lv_mask;
   logic [NOUT-1:0]          ed_mask;
   logic [NOUT-1:0][NZONE-1:0] zmask;
   logic                     vid_fail;
   logic                     frame;
   logic                     ivl_end;
   logic [CW-1:0]            ivl_lim;
   logic [NZONE-1:0]         vrise;
   logic [NSTAT-1:0]         brise;
   logic [31:0]              status;

   always_comb begin
      s_nxt  = s_r;
      access = PSEL_I && PENABLE_I;
      // Timebase and frame pacing
      s_nxt.tick = 1'b0;
      if (s_r.tick_cnt == '0) begin
         s_nxt.tick_cnt = TCW'(TICK_CYC - 1);
         s_nxt.tick     = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt - TCW'(1);
      end
      frame = (s_r.fr_cnt == '0);
      s_nxt.fr_cnt = frame ? FCW'(FRAME_CYC - 1) : s_r.fr_cnt - FCW'(1);
      // Zone qualification, sampled once per frame
      for (int z = 0; z < NZONE; z++) begin
         hit_now[z] = s_r.zen[z] && ZONE_DET_I[z] && ZONE_DIR_OK_I[z] &&
                      (!s_r.zbike[z] || ZONE_BIKE_CLS_I[z]);
         vrise[z]   = hit_now[z] && !s_r.det[z];
         zone_ext[z]  = s_r.zbike[z] && (s_r.zmap[z][`DCOC_ZM_EXT +: TW] != '0);
         zone_time[z] = s_r.zmap[z][`DCOC_ZM_EXT +: TW];
      end
      if (frame) s_nxt.det = hit_now;
      // Zone to output mapping and combination
      vid_fail = !VIDEO_OK_I || VIDEO_INTERF_I || POWER_FAIL_I;
      for (int c = 0; c < NOUT; c++) begin
         for (int z = 0; z < NZONE; z++) begin
            zmask[c][z] = s_r.zen[z] &&
                          (s_r.zmap[z][`DCOC_ZM_CH +: `DCOC_CH_W] == `DCOC_CH_W'(c));
         end
         ch_def[c]  = |zmask[c];
         ch_pres[c] = s_r.comb_and[c] ? (ch_def[c] && &(zone_call | ~zmask[c]))
                                      : |(zone_call & zmask[c]);
         ch_edit[c] = s_r.edit && (32'(s_r.ezone) < NZONE) &&
                      (s_r.zmap[s_r.ezone][`DCOC_ZM_CH +: `DCOC_CH_W] == `DCOC_CH_W'(c));
         ch_const[c] = s_r.oen[c] && (LEARN_I ||
                       (LOW_VIS_I && ch_def[c]) || ch_edit[c]);
         ch_rec[c]   = s_r.oen[c] && vid_fail;
         ch_pres[c]  = ch_pres[c] && s_r.oen[c];
      end
      lv_mask = ch_def & s_r.oen;
      ed_mask = ch_edit & s_r.oen;
      // Statistics binning
      case (s_r.ssel)
         dcoc_pkg::DCOC_IVL_5:  ivl_lim = CW'(`DCOC_IVL_M5 * `DCOC_TPM);
         dcoc_pkg::DCOC_IVL_15: ivl_lim = CW'(`DCOC_IVL_M15 * `DCOC_TPM);
         dcoc_pkg::DCOC_IVL_30: ivl_lim = CW'(`DCOC_IVL_M30 * `DCOC_TPM);
         dcoc_pkg::DCOC_IVL_60: ivl_lim = CW'(`DCOC_IVL_M60 * `DCOC_TPM);
         default:               ivl_lim = '1;
      endcase
      if (s_r.ssel == dcoc_pkg::DCOC_IVL_CYCLE) begin
         ivl_end = CYCLE_END_I;
      end else begin
         ivl_end = s_r.tick && (s_r.ival >= ivl_lim - CW'(1));
      end
      if (ivl_end) s_nxt.ival = '0;
      else if (s_r.tick) s_nxt.ival = s_r.ival + CW'(1);
      for (int i = 0; i < NSTAT; i++) begin
         brise[i] = BIKE_CNT_DET_I[i] && !s_r.bdet[i];
         if (frame) begin
            s_nxt.bdet[i] = BIKE_CNT_DET_I[i];
            if (vrise[i]) s_nxt.vcnt[i] = s_r.vcnt[i] + CW'(1);
            if (hit_now[i]) s_nxt.occ[i] = s_r.occ[i] + CW'(1);
            if (brise[i]) s_nxt.bcnt[i] = s_r.bcnt[i] + CW'(1);
         end
         if (ivl_end) begin
            s_nxt.vsav[i] = s_nxt.vcnt[i];
            s_nxt.osav[i] = s_nxt.occ[i];
            s_nxt.bsav[i] = s_nxt.bcnt[i];
            s_nxt.vcnt[i] = '0;
            s_nxt.occ[i]  = '0;
            s_nxt.bcnt[i] = '0;
         end
      end
      // Register read decode
      status = '0;
      status[0] = LEARN_I;
      status[1] = LOW_VIS_I;
      status[2] = VIDEO_OK_I;
      status[3] = VIDEO_INTERF_I;
      status[4] = POWER_FAIL_I;
      status[5] = s_r.edit;
      status[6] = s_r.dirty;
      hit = 1'b1;
      rd  = '0;
      case (PADDR_I)
         `DCOC_A_CTRL: begin
            rd[`DCOC_CTRL_EDIT]       = s_r.edit;
            rd[`DCOC_CTRL_EZONE +: ZW] = s_r.ezone;
         end
         `DCOC_A_ZEN:   rd[NZONE-1:0] = s_r.zen;
         `DCOC_A_ZBIKE: rd[NZONE-1:0] = s_r.zbike;
         `DCOC_A_COMB:  rd[NOUT-1:0]  = s_r.comb_and;
         `DCOC_A_OEN:   rd[NOUT-1:0]  = s_r.oen;
         `DCOC_A_STAT:  rd            = status;
         `DCOC_A_CALL:  rd[NOUT-1:0]  = CALL_O;
         `DCOC_A_SCFG:  rd[2:0]       = s_r.ssel;
         default:       hit           = 1'b0;
      endcase
      for (int z = 0; z < NZONE; z++) begin
         if (PADDR_I == `DCOC_A_ZMAP + 12'(4 * z)) begin
            hit = 1'b1;
            rd  = {16'h0000, s_r.zmap[z]};
         end
      end
      for (int c = 0; c < NOUT; c++) begin
         if (PADDR_I == `DCOC_A_CCFG + 12'(4 * c)) begin
            hit = 1'b1;
            rd  = {16'h0000, s_r.ccfg[c]};
         end
      end
      for (int i = 0; i < NSTAT; i++) begin
         if (PADDR_I == `DCOC_A_VCNT + 12'(4 * i)) begin
            hit = 1'b1;
            rd  = {16'h0000, s_r.vsav[i]};
         end
         if (PADDR_I == `DCOC_A_OCC + 12'(4 * i)) begin
            hit = 1'b1;
            rd  = {16'h0000, s_r.osav[i]};
         end
         if (PADDR_I == `DCOC_A_BCNT + 12'(4 * i)) begin
            hit = 1'b1;
            rd  = {16'h0000, s_r.bsav[i]};
         end
      end
      // One wait state, then the access completes
      if (access && !s_r.ready) begin
         s_nxt.ready = 1'b1;
         s_nxt.err   = !hit;
         s_nxt.rdata = hit ? rd : 32'h00000000;
      end else begin
         s_nxt.ready = 1'b0;
         s_nxt.err   = 1'b0;
      end
      if (access && s_r.ready && PWRITE_I && hit) begin
         case (PADDR_I)
            `DCOC_A_CTRL: begin
               s_nxt.edit  = PWDATA_I[`DCOC_CTRL_EDIT];
               s_nxt.ezone = PWDATA_I[`DCOC_CTRL_EZONE +: ZW];
            end
            `DCOC_A_ZEN:   s_nxt.zen      = PWDATA_I[NZONE-1:0];
            `DCOC_A_ZBIKE: s_nxt.zbike    = PWDATA_I[NZONE-1:0];
            `DCOC_A_COMB:  s_nxt.comb_and = PWDATA_I[NOUT-1:0];
            `DCOC_A_OEN:   s_nxt.oen      = PWDATA_I[NOUT-1:0];
            `DCOC_A_SCFG:  s_nxt.ssel     = dcoc_pkg::dcoc_ivl_e'(PWDATA_I[2:0]);
            default:       s_nxt.ssel     = s_nxt.ssel;
         endcase
         for (int z = 0; z < NZONE; z++) begin
            if (PADDR_I == `DCOC_A_ZMAP + 12'(4 * z)) s_nxt.zmap[z] = PWDATA_I[GW-1:0];
         end
         for (int c = 0; c < NOUT; c++) begin
            if (PADDR_I == `DCOC_A_CCFG + 12'(4 * c)) s_nxt.ccfg[c] = PWDATA_I[GW-1:0];
         end
         // Save request: CTRL with saved bit acknowledges, other config writes raise
         if (PADDR_I == `DCOC_A_CTRL && PWDATA_I[`DCOC_CTRL_SAVED]) begin
            s_nxt.dirty = 1'b0;
         end else if (PADDR_I != `DCOC_A_STAT && PADDR_I != `DCOC_A_CALL &&
                      PADDR_I < `DCOC_A_VCNT) begin
            s_nxt.dirty = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign PRDATA_O       = s_r.rdata;
   assign PREADY_O       = s_r.ready;
   assign PSLVERR_O      = s_r.err;
   assign ZONE_IND_O     = s_r.det;
   assign CFG_SAVE_REQ_O = s_r.dirty;

   // Per-zone stage: bicycle extension, plain presence otherwise
   for (genvar z = 0; z < NZONE; z++) begin : g_zone
      dcoc_chan #(
         .TW (TW)
      ) u_zone (
         .clk_i        (CLK_SYS_I),
         .arst_n_i     (ARST_N_I),
         .tick_i       (s_r.tick),
         .pres_i       (s_r.det[z]),
         .mode_i       (zone_ext[z] ? dcoc_pkg::DCOC_MODE_EXT : dcoc_pkg::DCOC_MODE_PRES),
         .time_i       (zone_time[z]),
         .recall_i     (1'b0),
         .recall_sel_i (dcoc_pkg::DCOC_REC_CONST),
         .const_i      (1'b0),
         .call_o       (zone_call[z])
      );
   end

   // Per-output stage
   for (genvar c = 0; c < NOUT; c++) begin : g_out
      dcoc_chan #(
         .TW (TW)
      ) u_out (
         .clk_i        (CLK_SYS_I),
         .arst_n_i     (ARST_N_I),
         .tick_i       (s_r.tick),
         .pres_i       (ch_pres[c]),
         .mode_i       (dcoc_pkg::dcoc_mode_e'(s_r.ccfg[c][`DCOC_CC_MODE +: 2])),
         .time_i       (s_r.ccfg[c][`DCOC_CC_TIME +: TW]),
         .recall_i     (ch_rec[c]),
         .recall_sel_i (dcoc_pkg::dcoc_recall_e'(s_r.ccfg[c][`DCOC_CC_REC +: 2])),
         .const_i      (ch_const[c]),
         .call_o       (CALL_O[c])
      );
   end

   chk_learn_call: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      LEARN_I && $stable(s_r.ccfg) |=> (CALL_O & $past(s_r.oen)) == $past(s_r.oen))
      else $error("learning period without constant call");
   chk_low_vis: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      LOW_VIS_I && $stable(s_r.ccfg) |=> (CALL_O & $past(lv_mask)) == $past(lv_mask))
      else $error("low visibility without constant call");
   chk_edit_hold: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      s_r.edit && $stable(s_r.ccfg) |=> (CALL_O & $past(ed_mask)) == $past(ed_mask))
      else $error("edited zone output not held");
   chk_apb_answer: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
      else $error("bus answer not after one wait");
   chk_bike_only: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      frame |=> (ZONE_IND_O & $past(s_r.zbike) & ~$past(ZONE_BIKE_CLS_I)) == '0)
      else $error("bicycle zone detected a motor vehicle");
endmodule // dcoc_top

// ### tb/dcoc_ctl_model.sv
// Signal controller detector input model: counts call onsets on channel 0
`timescale 1ns/100ps
module dcoc_ctl_model #(
   parameter int NOUT = 8
) (
   input  wire logic            clk_i,
   input  wire logic [NOUT-1:0] call_i,
   output int                   onsets_o
);
   int   cnt_r  = 0;
   logic last_r = 1'b0;
   assign onsets_o = cnt_r;
   always @(posedge clk_i) begin
      if (call_i[0] === 1'b1 && last_r !== 1'b1) cnt_r <= cnt_r + 1;
      last_r <= call_i[0];
   end
endmodule // dcoc_ctl_model

// ### tb/test_dcoc_top.sv
// Self-checking bench for the call conditioner
`include "dcoc_consts.svh"
`timescale 1ns/100ps
module test_dcoc_top;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, e, save;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [23:0] det = '0, dir = '1, bike = '0, ind;
   logic        vok = 1, vint = 0, pfail = 0, lowvis = 0, learn = 0, cyc_end = 0;
   logic [5:0]  bcd = '0;
   logic [7:0]  call;
   int          miscompares = 0, samples_checked = 0, onsets, n0;

   dcoc_top #(.TICK_CYC(20), .FRAME_CYC(4)) i_dut (
      .CLK_SYS_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .ZONE_DET_I(det), .ZONE_DIR_OK_I(dir), .ZONE_BIKE_CLS_I(bike),
      .BIKE_CNT_DET_I(bcd), .VIDEO_OK_I(vok), .VIDEO_INTERF_I(vint), .POWER_FAIL_I(pfail),
      .LOW_VIS_I(lowvis), .LEARN_I(learn), .CYCLE_END_I(cyc_end), .CALL_O(call),
      .ZONE_IND_O(ind), .CFG_SAVE_REQ_O(save));

   dcoc_ctl_model #(.NOUT(8)) i_ctl (.clk_i(clk), .call_i(call), .onsets_o(onsets));

   task automatic end_sim;
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   initial forever #2.5 clk = ~clk;

   initial begin
      cyc(20000);
      miscompares++;
      end_sim;
   end

   initial begin
      cyc(8);
      rst_n <= 1;
      chk("call_reset", 32'h0, call);
      apb(1, `DCOC_A_ZEN, 32'h7);
      apb(1, `DCOC_A_ZBIKE, 32'h2);
      apb(1, `DCOC_A_OEN, 32'h3);
      for (int z = 0; z < 3; z++) apb(1, `DCOC_A_ZMAP + 12'(4 * z), 32'(z == 1));
      for (int c = 0; c < 2; c++) apb(1, `DCOC_A_CCFG + 12'(4 * c), 32'h0);
      apb(0, 12'hFFC, 32'h0);
      chk("unmapped_err", 32'h1, e);
      chk("unmapped_data", 32'h0, q);
      det <= 24'h1;
      cyc(20);
      chk("or_call", 32'h1, call[0]);
      chk("zone_ind", 32'h1, ind[0]);
      dir <= '0;
      cyc(20);
      chk("wrong_dir", 32'h0, call[0]);
      dir <= '1;
      det <= 24'h2;
      cyc(20);
      chk("bike_nocls", 32'h0, call[1]);
      bike <= '1;
      cyc(20);
      chk("bike_cls", 32'h1, call[1]);
      chk("bike_other", 32'h0, call[0]);
      bike <= '0;
      det <= 24'h0;
      apb(1, `DCOC_A_COMB, 32'h1);
      det <= 24'h1;
      cyc(20);
      chk("and_part", 32'h0, call[0]);
      det <= 24'h5;
      cyc(20);
      chk("and_all", 32'h1, call[0]);
      det <= 24'h0;
      apb(1, `DCOC_A_COMB, 32'h0);
      for (int k = 0; k < 6; k++) begin
         case (k)
            0: learn <= 1;
            1: lowvis <= 1;
            2: apb(1, `DCOC_A_CTRL, 32'h1);
            3: vok <= 0;
            4: vint <= 1;
            default: pfail <= 1;
         endcase
         cyc(20);
         chk("forced_on", 32'h1, call[0]);
         learn <= 0;
         lowvis <= 0;
         vok <= 1;
         vint <= 0;
         pfail <= 0;
         if (k == 2) apb(1, `DCOC_A_CTRL, 32'h0);
         cyc(20);
         chk("forced_off", 32'h0, call[0]);
      end
      apb(1, `DCOC_A_CCFG, 32'h201);
      apb(0, `DCOC_A_CCFG, 32'h0);
      chk("ccfg_rd", 32'h201, q);
      n0 = onsets;
      det <= 24'h1;
      cyc(12);
      chk("pulse_on", 32'h1, call[0]);
      cyc(150);
      chk("pulse_off", 32'h0, call[0]);
      chk("pulse_cnt", n0 + 1, onsets);
      det <= 24'h0;
      apb(1, `DCOC_A_CCFG, 32'h202);
      det <= 24'h1;
      cyc(20);
      det <= 24'h0;
      cyc(15);
      chk("ext_hold", 32'h1, call[0]);
      cyc(100);
      chk("ext_end", 32'h0, call[0]);
      apb(1, `DCOC_A_CCFG, 32'h203);
      det <= 24'h1;
      cyc(12);
      chk("dly_wait", 32'h0, call[0]);
      cyc(100);
      chk("dly_call", 32'h1, call[0]);
      det <= 24'h0;
      for (int k = 1; k < 3; k++) begin
         apb(1, `DCOC_A_CCFG, 32'h200 | 32'(k << 2));
         vok <= 0;
         cyc(10);
         chk("recall_on", 32'h1, call[0]);
         cyc(40);
         chk("recall_gap", 32'h0, call[0]);
         cyc(40);
         chk("recall_again", 32'(k == 2), call[0]);
         vok <= 1;
      end
      apb(1, `DCOC_A_ZMAP + 12'h004, 32'h201);
      bike <= '1;
      det <= 24'h2;
      cyc(12);
      det <= 24'h0;
      cyc(15);
      chk("bike_ext", 32'h1, call[1]);
      cyc(60);
      chk("bike_ext_end", 32'h0, call[1]);
      bike <= '0;
      chk("dirty", 32'h1, save);
      apb(1, `DCOC_A_CTRL, 32'h8000_0000);
      cyc(2);
      chk("saved", 32'h0, save);
      apb(1, `DCOC_A_SCFG, 32'h4);
      cyc_end <= 1;
      cyc(1);
      cyc_end <= 0;
      for (int k = 0; k < 4; k++) begin
         det <= 24'(~k & 1);
         bcd <= 6'(~k & 1);
         cyc(8);
      end
      cyc_end <= 1;
      cyc(1);
      cyc_end <= 0;
      apb(0, `DCOC_A_VCNT, 32'h0);
      chk("veh_count", 32'h2, q);
      apb(0, `DCOC_A_OCC, 32'h0);
      chk("occupancy", 32'h4, q);
      apb(0, `DCOC_A_BCNT, 32'h0);
      chk("bike_count", 32'h2, q);
      end_sim;
   end
endmodule // test_dcoc_top
